// File: design/pmcs_pkg.sv
// constants, types and register map for the power mode clock switch
// Overview of operation
// R1 - a switch takes two old-clock cycles then three to four new-clock cycles
// R2 - status bits: primary ready, internal stable, secondary running at fixed positions
// R3 - primary ready is set only while the primary clock drives the device
// R4 - internal stable is set only while the stable fast internal oscillator drives
// R5 - secondary running is set only while the secondary oscillator drives the device
// R6 - all status bits clear means slow RC or unsettled internal oscillator
// R7 - internal configured as primary may show primary ready and internal stable
// R8 - moving from internal-as-primary into an internal RC mode clears primary ready
// R9 - each sleep enters sleep or idle per the idle enable bit at that moment
// R10 - in every run mode core and peripheral clocks stay active; the code gates both during the new-clock cycles of each switch
// R11 - after reset start in primary run with primary ready unless two-speed
// R12 - select value 01 requests secondary run mode
// R13 - entering secondary run stops primary oscillator, sets secondary, clears primary
// R14 - select 01 with secondary oscillator disabled does not enter secondary run
// R15 - secondary enabled but not running holds device clocks off until it starts
// R16 - returning to primary keeps secondary clocking until primary is ready
// R17 - switch back done clears secondary running and sets primary ready
// R18 - wake-up leaves idle enable and select bits alone, secondary keeps running
// R19 - software should start the secondary oscillator before selecting it
// R20 - the three status bits are read-only to software
package pmcs_pkg;

  localparam logic [11:0] PMCS_OFF_OSC_CTL = 12'h000;
  localparam logic [11:0] PMCS_OFF_TMR_CTL = 12'h004;
  localparam logic [11:0] PMCS_OFF_TUNE = 12'h008;

  localparam int PMCS_BIT_IDLE_EN = 7;
  localparam int PMCS_BIT_PRI_RDY = 3;
  localparam int PMCS_BIT_INT_STB = 2;
  localparam int PMCS_BIT_SECONDARY_RUN_MODE = 6;
  localparam int PMCS_BIT_SEC_EN = 3;

  localparam logic [1:0] PMCS_SEL_PRI = 2'h0;
  localparam logic [1:0] PMCS_SEL_SEC = 2'h1;
  localparam logic [1:0] PMCS_SEL_RST = 2'h0;
  localparam logic PMCS_IDLE_RST = 1'b0;
  localparam logic PMCS_SEC_EN_RST = 1'b0;
  localparam logic [7:0] PMCS_TUNE_RST = 8'h00;
  localparam logic [7:0] PMCS_TUNE_MASK = 8'hDF;

  localparam logic [2:0] PMCS_OLD_CYC = 3'h2;
  localparam logic [2:0] PMCS_NEW_CYC = 3'h4;

  localparam logic [1:0] PMCS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PMCS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PMCS_SRC_PRI, PMCS_SRC_SEC, PMCS_SRC_INT} pmcs_src_t;
  typedef enum logic [1:0] {PMCS_PWR_RUN, PMCS_PWR_IDLE, PMCS_PWR_SLEEP} pmcs_pwr_t;
  typedef enum logic [2:0] {PMCS_ST_BOOT, PMCS_ST_RUN, PMCS_ST_WAIT, PMCS_ST_OLD,
                            PMCS_ST_NEW} pmcs_state_t;

  typedef struct packed {
    logic pri_ready;
    logic int_stable;
    logic sec_running;
  } pmcs_flags_t;

  typedef struct packed {
    logic pri_osc_ready;
    logic int_osc_stable;
    logic sec_osc_running;
    logic cfg_int_primary;
    logic two_speed_en;
  } pmcs_pins_t;

endpackage

// File: design/pmcs_top.sv
// clock source switch sequencer with status flags and sleep/idle control
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module pmcs_top
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire pmcs_pkg::pmcs_pins_t osc_pins,
  output logic core_clk_en,
  output logic periph_clk_en,
  output pmcs_pkg::pmcs_src_t clk_src_sel,
  output logic pri_osc_en,
  output logic sec_osc_en,
  output pmcs_pkg::pmcs_pwr_t pwr_mode,
  output pmcs_pkg::pmcs_flags_t flags
);

  // oscillator status and straps come from other domains
  pmcs_pkg::pmcs_pins_t sync1_q;
  pmcs_pkg::pmcs_pins_t sync2_q;

  // software visible control
  logic idle_en_q;
  logic [1:0] src_sel_q;
  logic sec_en_q;
  logic [7:0] tune_q;

  // switch sequencer
  pmcs_pkg::pmcs_state_t state_q;
  pmcs_pkg::pmcs_src_t cur_q;
  pmcs_pkg::pmcs_src_t tgt_q;
  pmcs_pkg::pmcs_src_t want_src;
  pmcs_pkg::pmcs_pwr_t pwr_q;
  logic [2:0] cnt_q;
  logic want_ready;
  logic tgt_ready;
  pmcs_pkg::pmcs_flags_t flags_q;
  logic core_en_q;
  logic periph_en_q;
  pmcs_pkg::pmcs_src_t sel_q;
  logic pri_en_q;

  // bus slave state
  logic aw_got_q;
  logic w_got_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_write;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;

  // two flops before any logic looks at the pins
  // no reset here: the straps must have settled two edges before the first edge after release,
  // otherwise the boot step would always see two-speed start-up as off [R11]
  always_ff @(posedge aclk)
  begin
    sync1_q <= osc_pins;
    sync2_q <= sync1_q;
  end

  // write channels are taken independently, one write outstanding at a time
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign do_write = aw_got_q && w_got_q && !bvalid_q;
  assign wr_hit = (awaddr_q == pmcs_pkg::PMCS_OFF_OSC_CTL) ||
                  (awaddr_q == pmcs_pkg::PMCS_OFF_TMR_CTL) ||
                  (awaddr_q == pmcs_pkg::PMCS_OFF_TUNE);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= pmcs_pkg::PMCS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr[11:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? pmcs_pkg::PMCS_RESP_OKAY : pmcs_pkg::PMCS_RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // control registers; status bits have no write path at all [R20]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      idle_en_q <= pmcs_pkg::PMCS_IDLE_RST;
      src_sel_q <= pmcs_pkg::PMCS_SEL_RST;
      sec_en_q <= pmcs_pkg::PMCS_SEC_EN_RST;
      tune_q <= pmcs_pkg::PMCS_TUNE_RST;
    end
    else if (do_write && wstrb0_q)
    begin
      if (awaddr_q == pmcs_pkg::PMCS_OFF_OSC_CTL)
      begin
        idle_en_q <= wdata_q[pmcs_pkg::PMCS_BIT_IDLE_EN];
        src_sel_q <= wdata_q[1:0];
      end
      if (awaddr_q == pmcs_pkg::PMCS_OFF_TMR_CTL)
      begin
        sec_en_q <= wdata_q[pmcs_pkg::PMCS_BIT_SEC_EN];
      end
      if (awaddr_q == pmcs_pkg::PMCS_OFF_TUNE)
      begin
        tune_q <= wdata_q[7:0] & pmcs_pkg::PMCS_TUNE_MASK;
      end
    end
  end

  // read mux; flags are placed at their fixed positions [R2]
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr[11:0])
      pmcs_pkg::PMCS_OFF_OSC_CTL:
      begin
        rd_word[pmcs_pkg::PMCS_BIT_IDLE_EN] = idle_en_q;
        rd_word[pmcs_pkg::PMCS_BIT_PRI_RDY] = flags_q.pri_ready; // [R2]
        rd_word[pmcs_pkg::PMCS_BIT_INT_STB] = flags_q.int_stable; // [R2]
        rd_word[1:0] = src_sel_q;
      end
      pmcs_pkg::PMCS_OFF_TMR_CTL:
      begin
        rd_word[pmcs_pkg::PMCS_BIT_SECONDARY_RUN_MODE] = flags_q.sec_running; // [R2]
        rd_word[pmcs_pkg::PMCS_BIT_SEC_EN] = sec_en_q;
      end
      pmcs_pkg::PMCS_OFF_TUNE:
      begin
        rd_word[7:0] = tune_q;
      end
      default:
      begin
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= pmcs_pkg::PMCS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? pmcs_pkg::PMCS_RESP_OKAY : pmcs_pkg::PMCS_RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // requested source; a disabled secondary leaves the current source in place
  always_comb
  begin
    if (src_sel_q == pmcs_pkg::PMCS_SEL_PRI)
    begin
      want_src = pmcs_pkg::PMCS_SRC_PRI;
    end
    else if (src_sel_q == pmcs_pkg::PMCS_SEL_SEC)
    begin
      want_src = sec_en_q ? pmcs_pkg::PMCS_SRC_SEC : cur_q; // [R12] [R14]
    end
    else
    begin
      want_src = pmcs_pkg::PMCS_SRC_INT;
    end
  end

  // the slow RC is always available, so internal never waits
  always_comb
  begin
    case (want_src)
      pmcs_pkg::PMCS_SRC_PRI: want_ready = sync2_q.pri_osc_ready;
      pmcs_pkg::PMCS_SRC_SEC: want_ready = sync2_q.sec_osc_running;
      default: want_ready = 1'b1;
    endcase
    case (tgt_q)
      pmcs_pkg::PMCS_SRC_PRI: tgt_ready = sync2_q.pri_osc_ready; // [R16]
      pmcs_pkg::PMCS_SRC_SEC: tgt_ready = sync2_q.sec_osc_running; // [R15]
      default: tgt_ready = 1'b1;
    endcase
  end

  // switch sequencer: wait for stable source, old-clock cycles, new-clock cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= pmcs_pkg::PMCS_ST_BOOT;
      cur_q <= pmcs_pkg::PMCS_SRC_PRI;
      tgt_q <= pmcs_pkg::PMCS_SRC_PRI;
      cnt_q <= 3'h0;
    end
    else
    begin
      case (state_q)
        pmcs_pkg::PMCS_ST_BOOT:
        begin
          // strap is caught after release; two-speed starts on internal
          cur_q <= sync2_q.two_speed_en ? pmcs_pkg::PMCS_SRC_INT : pmcs_pkg::PMCS_SRC_PRI; // [R11]
          state_q <= pmcs_pkg::PMCS_ST_RUN;
        end
        pmcs_pkg::PMCS_ST_RUN:
        begin
          // no switching while the device sleeps or idles
          if (pwr_q == pmcs_pkg::PMCS_PWR_RUN && want_src != cur_q)
          begin
            tgt_q <= want_src;
            cnt_q <= 3'h0;
            state_q <= want_ready ? pmcs_pkg::PMCS_ST_OLD : pmcs_pkg::PMCS_ST_WAIT;
          end
        end
        pmcs_pkg::PMCS_ST_WAIT:
        begin
          if (want_src == cur_q)
          begin
            state_q <= pmcs_pkg::PMCS_ST_RUN; // request withdrawn
          end
          else if (tgt_ready)
          begin
            cnt_q <= 3'h0;
            state_q <= pmcs_pkg::PMCS_ST_OLD; // [R15] [R16]
          end
        end
        pmcs_pkg::PMCS_ST_OLD:
        begin
          if (cnt_q == pmcs_pkg::PMCS_OLD_CYC - 3'h1)
          begin
            cnt_q <= 3'h0;
            state_q <= pmcs_pkg::PMCS_ST_NEW; // [R1]
          end
          else
          begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        pmcs_pkg::PMCS_ST_NEW:
        begin
          if (cnt_q == pmcs_pkg::PMCS_NEW_CYC - 3'h1)
          begin
            cnt_q <= 3'h0;
            cur_q <= tgt_q; // [R1] [R13] [R17]
            state_q <= pmcs_pkg::PMCS_ST_RUN;
          end
          else
          begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        default:
        begin
          state_q <= pmcs_pkg::PMCS_ST_BOOT;
        end
      endcase
    end
  end

  // power mode; a wake-up never touches the idle enable or select bits [R18]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwr_q <= pmcs_pkg::PMCS_PWR_RUN;
    end
    else if (pwr_q == pmcs_pkg::PMCS_PWR_RUN)
    begin
      if (sleep_req && state_q == pmcs_pkg::PMCS_ST_RUN)
      begin
        pwr_q <= idle_en_q ? pmcs_pkg::PMCS_PWR_IDLE : pmcs_pkg::PMCS_PWR_SLEEP; // [R9]
      end
    end
    else if (wake_req)
    begin
      pwr_q <= pmcs_pkg::PMCS_PWR_RUN; // [R18]
    end
  end

  // status flags follow the source in use, not the request [R3] [R4] [R5] [R6]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags_q <= '0;
    end
    else if (state_q == pmcs_pkg::PMCS_ST_BOOT)
    begin
      flags_q.pri_ready <= !sync2_q.two_speed_en; // [R11]
      flags_q.int_stable <= sync2_q.two_speed_en && sync2_q.int_osc_stable;
      flags_q.sec_running <= 1'b0;
    end
    else
    begin
      // internal modes leave primary ready clear even at the same rate [R8]
      flags_q.pri_ready <= cur_q == pmcs_pkg::PMCS_SRC_PRI; // [R3] [R17]
      // slow RC selected in tuning means no stable fast output drives us
      flags_q.int_stable <= sync2_q.int_osc_stable && !tune_q[7] &&
                            (cur_q == pmcs_pkg::PMCS_SRC_INT ||
                             (cur_q == pmcs_pkg::PMCS_SRC_PRI &&
                              sync2_q.cfg_int_primary)); // [R4] [R6] [R7]
      flags_q.sec_running <= cur_q == pmcs_pkg::PMCS_SRC_SEC; // [R5] [R13]
    end
  end

  // clock gating and oscillator enables, registered to keep outputs glitch free
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_en_q <= 1'b0;
      periph_en_q <= 1'b0;
      sel_q <= pmcs_pkg::PMCS_SRC_PRI;
      pri_en_q <= 1'b1;
    end
    else
    begin
      // run modes keep both on except in the boot step and while waiting for the secondary; the new-clock phase gates them for a clean edge
      core_en_q <= pwr_q == pmcs_pkg::PMCS_PWR_RUN &&
                   state_q != pmcs_pkg::PMCS_ST_NEW &&
                   state_q != pmcs_pkg::PMCS_ST_BOOT &&
                   !(state_q == pmcs_pkg::PMCS_ST_WAIT &&
                     tgt_q == pmcs_pkg::PMCS_SRC_SEC); // [R10] [R15]
      periph_en_q <= pwr_q != pmcs_pkg::PMCS_PWR_SLEEP &&
                     state_q != pmcs_pkg::PMCS_ST_NEW &&
                     state_q != pmcs_pkg::PMCS_ST_BOOT &&
                     !(state_q == pmcs_pkg::PMCS_ST_WAIT &&
                       tgt_q == pmcs_pkg::PMCS_SRC_SEC); // [R10] [R15]
      sel_q <= (state_q == pmcs_pkg::PMCS_ST_NEW) ? tgt_q : cur_q; // [R16]
      // primary stops in secondary run, internal run and sleep, restarts on a return request
      pri_en_q <= pwr_q != pmcs_pkg::PMCS_PWR_SLEEP &&
                  (cur_q == pmcs_pkg::PMCS_SRC_PRI ||
                   want_src == pmcs_pkg::PMCS_SRC_PRI ||
                   (state_q != pmcs_pkg::PMCS_ST_RUN &&
                    tgt_q == pmcs_pkg::PMCS_SRC_PRI)); // [R13] [R16]
    end
  end

  assign core_clk_en = core_en_q;
  assign periph_clk_en = periph_en_q;
  assign clk_src_sel = sel_q;
  assign pri_osc_en = pri_en_q;
  assign sec_osc_en = sec_en_q; // keeps running across wake-up [R18]
  assign pwr_mode = pwr_q;
  assign flags = flags_q;

endmodule

// File: verification/pmcs_chk.sv
// concurrent checks on the clock switch ports
`timescale 1ns/1ps
module pmcs_chk
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire pmcs_pkg::pmcs_pins_t osc_pins,
  input wire logic core_clk_en,
  input wire pmcs_pkg::pmcs_src_t clk_src_sel,
  input wire logic pri_osc_en,
  input wire logic sec_osc_en,
  input wire pmcs_pkg::pmcs_pwr_t pwr_mode,
  input wire pmcs_pkg::pmcs_flags_t flags
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // flags load on the first edge after release
  property p_boot;
    $rose(aresetn) |-> ##[1:2] (flags.pri_ready == !osc_pins.two_speed_en);
  endproperty
  property p_sec_in;
    $rose(flags.sec_running) |-> !flags.pri_ready && clk_src_sel == pmcs_pkg::PMCS_SRC_SEC;
  endproperty
  // the primary may stop a little after the handover, never long after
  property p_pri_off;
    $rose(flags.sec_running) |-> ##[0:2] !pri_osc_en;
  endproperty
  property p_sec_out;
    $fell(flags.sec_running) |-> flags.pri_ready && clk_src_sel == pmcs_pkg::PMCS_SRC_PRI;
  endproperty
  property p_sec_en;
    flags.sec_running |-> sec_osc_en;
  endproperty
  // a gated run clock must stay off for at least three cycles, then come back
  property p_gap;
    $fell(core_clk_en) && pwr_mode == pmcs_pkg::PMCS_PWR_RUN |-> (!core_clk_en)[*3] ##[1:300]
      core_clk_en;
  endproperty
  property p_keep;
    $rose(pri_osc_en) && flags.sec_running |-> core_clk_en[*2];
  endproperty
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_boot: assert property (p_boot) else $error("boot flags wrong");
  a_sec_in: assert property (p_sec_in) else $error("secondary entry wrong");
  a_pri_off: assert property (p_pri_off) else $error("primary kept on");
  a_sec_out: assert property (p_sec_out) else $error("return flags wrong");
  a_sec_en: assert property (p_sec_en) else $error("secondary run while disabled");
  a_gap: assert property (p_gap) else $error("switch gap wrong");
  a_keep: assert property (p_keep) else $error("clock lost on return");
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  c_sec: cover property ($rose(flags.sec_running));
  c_back: cover property ($fell(flags.sec_running));
  c_idle: cover property (pwr_mode == pmcs_pkg::PMCS_PWR_IDLE);
endmodule
bind pmcs_top pmcs_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .osc_pins(osc_pins),
  .core_clk_en(core_clk_en), .clk_src_sel(clk_src_sel), .pri_osc_en(pri_osc_en),
  .sec_osc_en(sec_osc_en), .pwr_mode(pwr_mode), .flags(flags));

// File: verification/pmcs_osc_model.sv
// behavioural oscillator sources seen by the clock switch
`timescale 1ns/1ps
module pmcs_osc_model
(
  input wire logic aclk,
  input wire logic pri_osc_en,
  input wire logic sec_osc_en,
  input wire logic slow,
  output pmcs_pkg::pmcs_pins_t pins
);
  logic [5:0] pri_cnt_q = 6'h00;
  logic [5:0] sec_cnt_q = 6'h00;
  // start-up counters; a disabled oscillator stops at once, no graceful decay
  always @(posedge aclk)
  begin
    if (!pri_osc_en)
      pri_cnt_q <= 6'h00;
    else if (pri_cnt_q != 6'h3F)
      pri_cnt_q <= pri_cnt_q + 6'h01;
    if (!sec_osc_en)
      sec_cnt_q <= 6'h00;
    else if (sec_cnt_q != 6'h3F)
      sec_cnt_q <= sec_cnt_q + 6'h01;
  end
  // external primary, plain start-up; slow mode mimics a lazy crystal
  assign pins = '{pri_osc_ready: pri_cnt_q >= 6'h08, int_osc_stable: 1'b1,
    sec_osc_running: sec_cnt_q >= (slow ? 6'h28 : 6'h04), cfg_int_primary: 1'b0,
    two_speed_en: 1'b0};
endmodule

// File: verification/tb_top.sv
// self-checking bench for the power mode clock switch
`timescale 1ns/1ps
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic sleep_req = 1'b0, wake_req = 1'b0, slow = 1'b0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, core_en, periph_en, pri_en, sec_en;
  logic [1:0] bresp, rresp, rsp;
  pmcs_pkg::pmcs_pins_t pins;
  pmcs_pkg::pmcs_src_t src;
  pmcs_pkg::pmcs_pwr_t pwr;
  pmcs_pkg::pmcs_flags_t flags;
  int n_errors = 0, n_checks = 0, n_low;
  always #2.5 aclk = ~aclk;
  pmcs_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sleep_req(sleep_req), .wake_req(wake_req), .osc_pins(pins), .core_clk_en(core_en),
    .periph_clk_en(periph_en), .clk_src_sel(src), .pri_osc_en(pri_en), .sec_osc_en(sec_en),
    .pwr_mode(pwr), .flags(flags));
  pmcs_osc_model osc (.aclk(aclk), .pri_osc_en(pri_en), .sec_osc_en(sec_en), .slow(slow),
    .pins(pins));
  task automatic give_verdict();
    if (n_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // a used-up wait bound counts as a mismatch and ends the run
  task automatic bail();
    n_errors++;
    give_verdict();
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one bus transfer; handshakes judged at the negedge before the taking edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    logic ta, tw, got;
    got = 1'b0;
    if (wr)
    begin
      awaddr <= {20'h0, a};
      wdata <= {24'h0, d};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end
    else
    begin
      araddr <= {20'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    for (n = 0; n < 50 && !got; n++)
    begin
      @(negedge aclk);
      ta = (awvalid & awready) | (arvalid & arready);
      tw = wvalid & wready;
      got = wr ? bvalid : rvalid;
      rsp = wr ? bresp : rresp;
      rd = rdata;
      @(posedge aclk);
      if (ta)
      begin
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (tw)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    // a free edge keeps the next call from driving the same strobes in this time step
    @(posedge aclk);
    if (!got)
      bail();
  endtask
  // waits for the flags, counting cycles with the core clock gated
  task automatic wait_flags(input logic [2:0] f);
    int n;
    logic hit;
    hit = 1'b0;
    n_low = 0;
    for (n = 0; n < 400 && !hit; n++)
    begin
      @(negedge aclk);
      n_low += int'(!core_en);
      hit = (flags === f);
      @(posedge aclk);
    end
    if (!hit)
      bail();
  endtask
  task automatic t_reset();
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    check({core_en, periph_en, pwr}, {2'h3, pmcs_pkg::PMCS_PWR_RUN});
    @(posedge aclk);
    bus(0, pmcs_pkg::PMCS_OFF_OSC_CTL, 8'h00);
    check(rd, 32'h08);
    bus(0, pmcs_pkg::PMCS_OFF_TMR_CTL, 8'h00);
    check(rd, 32'h00);
  endtask
  task automatic t_regs();
    bus(1, pmcs_pkg::PMCS_OFF_TUNE, 8'hFF);
    bus(0, pmcs_pkg::PMCS_OFF_TUNE, 8'h00);
    check(rd, 32'hDF);
    bus(1, pmcs_pkg::PMCS_OFF_TUNE, 8'h00);
    bus(1, pmcs_pkg::PMCS_OFF_OSC_CTL, 8'h04);
    bus(0, pmcs_pkg::PMCS_OFF_OSC_CTL, 8'h00);
    check(rd, 32'h08);
    bus(1, pmcs_pkg::PMCS_OFF_TMR_CTL, 8'h40);
    bus(0, pmcs_pkg::PMCS_OFF_TMR_CTL, 8'h00);
    check(rd, 32'h00);
    bus(1, 12'h00C, 8'hFF);
    check(rsp, 32'h2);
    bus(0, 12'h00C, 8'h00);
    check(rsp, 32'h2);
    check(rd, 32'h0);
  endtask
  task automatic t_refuse();
    bus(1, pmcs_pkg::PMCS_OFF_OSC_CTL, 8'h01);
    repeat (20) @(posedge aclk);
    @(negedge aclk);
    check({src, flags}, {pmcs_pkg::PMCS_SRC_PRI, 3'b100});
    @(posedge aclk);
    bus(1, pmcs_pkg::PMCS_OFF_OSC_CTL, 8'h00);
  endtask
  task automatic t_sec();
    slow <= 1'b1;
    bus(1, pmcs_pkg::PMCS_OFF_TMR_CTL, 8'h08);
    bus(1, pmcs_pkg::PMCS_OFF_OSC_CTL, 8'h01);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    check(core_en, 1'b0);
    @(posedge aclk);
    wait_flags(3'b001);
    check(pri_en, 1'b0);
    bus(0, pmcs_pkg::PMCS_OFF_OSC_CTL, 8'h00);
    check(rd, 32'h01);
    bus(0, pmcs_pkg::PMCS_OFF_TMR_CTL, 8'h00);
    check(rd, 32'h48);
  endtask
  task automatic t_back();
    bus(1, pmcs_pkg::PMCS_OFF_OSC_CTL, 8'h00);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    check({core_en, src}, {1'b1, pmcs_pkg::PMCS_SRC_SEC});
    @(posedge aclk);
    wait_flags(3'b100);
    check(n_low, {29'h0, pmcs_pkg::PMCS_NEW_CYC});
    check(src, pmcs_pkg::PMCS_SRC_PRI);
  endtask
  // internal source: stable fast output, then slow RC, then back to primary
  task automatic t_int();
    bus(1, pmcs_pkg::PMCS_OFF_OSC_CTL, 8'h02);
    wait_flags(3'b010);
    check({src, pri_en}, {pmcs_pkg::PMCS_SRC_INT, 1'b0});
    bus(1, pmcs_pkg::PMCS_OFF_TUNE, 8'h80);
    wait_flags(3'b000);
    bus(1, pmcs_pkg::PMCS_OFF_TUNE, 8'h00);
    bus(1, pmcs_pkg::PMCS_OFF_OSC_CTL, 8'h00);
    wait_flags(3'b100);
  endtask
  task automatic do_sleep(input pmcs_pkg::pmcs_pwr_t m);
    sleep_req <= 1'b1;
    @(posedge aclk);
    sleep_req <= 1'b0;
    @(negedge aclk);
    check(pwr, m);
    @(negedge aclk);
    check({core_en, periph_en, pri_en}, {1'b0, {2{m == pmcs_pkg::PMCS_PWR_IDLE}}});
    repeat (6) @(posedge aclk);
    wake_req <= 1'b1;
    @(posedge aclk);
    wake_req <= 1'b0;
    @(negedge aclk);
    check(pwr, pmcs_pkg::PMCS_PWR_RUN);
    repeat (30) @(posedge aclk);
  endtask
  // idle then plain sleep: each sleep follows the idle bit of its moment
  task automatic t_sleep();
    bus(1, pmcs_pkg::PMCS_OFF_OSC_CTL, 8'h80);
    do_sleep(pmcs_pkg::PMCS_PWR_IDLE);
    bus(0, pmcs_pkg::PMCS_OFF_OSC_CTL, 8'h00);
    check({rd & 32'h83, sec_en}, {32'h80, 1'b1});
    bus(1, pmcs_pkg::PMCS_OFF_OSC_CTL, 8'h00);
    do_sleep(pmcs_pkg::PMCS_PWR_SLEEP);
  endtask
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_regs();
    t_refuse();
    t_sec();
    t_back();
    t_int();
    t_sleep();
    give_verdict();
  end
endmodule
